// [include/plb_pkg.sv]
// Purpose: Shared types and constants of the PLL mode and boot loader
// Assumes: 100 MHz core clock
// Notes: Strap decode and PLL ratio helpers live here
package plb_pkg;
  typedef struct packed {
    logic [1:0] pll_output_divider;
    logic [6:0] feedback;
    logic [5:0] refDiv;
  } plb_pll_t;

  typedef struct packed {
    logic valid;
    logic ctrl;
    logic [7:0] data;
  } plb_tok_t;

  typedef enum logic [2:0] {
    SRC_NONE, SRC_SPI, SRC_LINK, SRC_CHAN, SRC_OTP
  } plb_src_t;

  typedef enum logic [3:0] {
    S_LOCK, S_PICK, S_JTAG, S_DLY, S_ACK, S_SIZE, S_PROG, S_CRC,
    S_ENDIN, S_ENDOUT, S_RUN, S_FAIL
  } plb_state_t;

  localparam plb_pll_t PLB_PLL_M00 = '{2'h1, 7'h7a, 6'h00};
  localparam plb_pll_t PLB_PLL_M11 = '{2'h2, 7'h77, 6'h00};
  localparam plb_pll_t PLB_PLL_M10 = '{2'h2, 7'h31, 6'h00};
  localparam plb_pll_t PLB_PLL_M01 = '{2'h2, 7'h17, 6'h00};

  localparam int PLB_CLK_PERIOD_NS = 10;
  localparam int PLB_LINK_DLY_NS = 200;
  localparam int PLB_LINK_DLY_CYC =
    (PLB_LINK_DLY_NS + PLB_CLK_PERIOD_NS - 1) / PLB_CLK_PERIOD_NS;
  localparam int PLB_SPI_REF_CORE_KHZ = 400000;
  localparam int PLB_SPI_SCK_KHZ = 2500;
  localparam int PLB_SPI_HALF_CYC =
    PLB_SPI_REF_CORE_KHZ / PLB_SPI_SCK_KHZ / 2;

  localparam logic [7:0] PLB_SPI_READ_CMD = 8'h03;
  localparam logic [23:0] PLB_SPI_START_ADDR = 24'h000000;
  localparam logic [31:0] PLB_NULL_CHAN = 32'h0000ff02;
  localparam logic [7:0] PLB_CTRL_END = 8'h01;
  localparam logic [31:0] PLB_CRC_POLY = 32'hedb88320;
  localparam logic [31:0] PLB_CRC_INIT = 32'hffffffff;
  localparam logic [15:0] PLB_RAM_BASE = 16'h0000;
  localparam logic [15:0] PLB_OTP_BASE = 16'h0000;

  function automatic plb_pll_t plbPllDecode(input logic [1:0] mode);
    unique case (mode)
      2'b00: plbPllDecode = PLB_PLL_M00;
      2'b11: plbPllDecode = PLB_PLL_M11;
      2'b10: plbPllDecode = PLB_PLL_M10;
      2'b01: plbPllDecode = PLB_PLL_M01;
    endcase
  endfunction : plbPllDecode

  // Core/osc = (F+1) / (2*(R+1)*(divider+1))
  function automatic logic [9:0] plbPllDen(input plb_pll_t c);
    plbPllDen = 10'(({4'h0, c.refDiv} + 10'h1)
      * ({8'h0, c.pll_output_divider} + 10'h1) * 10'h2);
  endfunction : plbPllDen
endpackage : plb_pkg

// [rtl/plb_boot_loader.sv]
// Purpose: PLL strap decode and boot loader of one tile
// Assumes: Link tokens arrive already decoded from the link layer
// Notes: Image is size word, program words, CRC word
//
// Contract
// - Mode straps pick four fixed PLL settings
// - Core clock ratio follows feedback/reference/divider
// - Software may rewrite PLL settings after start
// - Straps 00 wait for JTAG, 01 reserved
// - Tile0 boots link or SPI, tile1 chanend
// - Codes 110/111 boot each tile independently
// - Size and CRC words arrive low byte first
// - Program loads at RAM bottom, runs there
// - CRC-32 reflected over size and program
// - Serial clock is core rate over 160
// - Read command, zero address, clock mode 0
// - Boot bytes shift least significant bit first
// - SPI boot uses the fixed pins only
// - Link B enabled about 200 ns after start
// - Link drives outputs low, releases pull-downs
// - First word names the acknowledge channel
// - Image, END in, END out, free, jump
// - Secure boot reads OTP from address zero
// - Each tile owns its private OTP
// - Reset low async, then lock, then boot
module plb_boot_loader
  import plb_pkg::*;
#(
  parameter int RAM_AW = 16,
  parameter int OTP_AW = 13
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic pllLock,
  input wire logic [1:0] pllModeStrap,
  input wire logic [4:2] bootStrap,
  input wire logic tileId,
  input wire logic secureBoot,
  input wire logic swPllWe,
  input wire plb_pll_t swPllCfg,
  output plb_pll_t pllCfg_r,
  output logic [7:0] ratioNum_r,
  output logic [9:0] ratioDen_r,
  input wire logic spiMiso,
  output logic spiSck_r,
  output logic spiSelN_r,
  output logic spiMosi_r,
  output logic spiPinEn_r,
  output logic linkBEn_r,
  output logic intLinksEn_r,
  output logic linkPullDownEn_r,
  output logic bootLinkOutLine0_r,
  output logic bootLinkOutLine1_r,
  output logic bootLinkOutOe_r,
  input wire logic bootLinkInLine0,
  input wire logic bootLinkInLine1,
  output logic linkTraffic_r,
  input wire plb_tok_t tokIn,
  output plb_tok_t tokOut_r,
  output logic [31:0] tokOutDest_r,
  output logic chanEnd0Alloc_r,
  output logic otpRd_r,
  output logic [OTP_AW-1:0] otpAddr_r,
  input wire logic [7:0] otpData,
  input wire logic otpValid,
  output logic ramWe_r,
  output logic [RAM_AW-1:0] ramAddr_r,
  output logic [7:0] ramData_r,
  output logic runStart_r,
  output logic [RAM_AW-1:0] runPc_r,
  output logic waitJtag_r,
  output logic bootReserved_r,
  output logic bootFail_r
);
  initial begin
    if (RAM_AW < 4 || RAM_AW > 16) $error("RAM_AW out of range");
    if (OTP_AW < 1 || OTP_AW > 16) $error("OTP_AW out of range");
  end

  localparam int LinkDlyA = PLB_LINK_DLY_CYC;

  plb_state_t state_r;
  plb_src_t src_r;
  logic [7:0] dlyCnt_r;
  logic [1:0] byteIdx_r;
  logic [31:0] word_r;
  logic [31:0] ackChan_r;
  logic [31:0] sizeWord_r;
  logic [RAM_AW-1:0] ptr_r;
  logic [RAM_AW:0] left_r;
  logic otpPend_r;
  logic [31:0] crc;
  logic spiByteV;
  logic [7:0] spiByte;

  // Boot source decode from straps and secure flag
  wire code00 = bootStrap[3:2] == 2'b00;
  wire code01 = bootStrap[3:2] == 2'b01;
  wire isSpiCode = bootStrap[3:2] == 2'b11;
  wire indep = bootStrap[4];
  wire tile0 = !tileId;
  plb_src_t srcPick;
  assign srcPick = secureBoot ? SRC_OTP :
    (code00 || code01) ? SRC_NONE :
    (isSpiCode && (indep || tile0)) ? SRC_SPI :
    (indep || tile0) ? SRC_LINK : SRC_CHAN;

  // Byte stream selection
  wire loading = state_r == S_ACK || state_r == S_SIZE
    || state_r == S_PROG || state_r == S_CRC;
  wire fromTok = src_r == SRC_LINK || src_r == SRC_CHAN;
  wire spiRun = src_r == SRC_SPI && state_r inside {S_SIZE, S_PROG, S_CRC};
  wire otpLoad = src_r == SRC_OTP && loading;
  wire inV = fromTok ? tokIn.valid && !tokIn.ctrl :
    src_r == SRC_SPI ? spiByteV :
    src_r == SRC_OTP ? otpValid && otpPend_r : 1'b0;
  wire [7:0] inB = fromTok ? tokIn.data :
    src_r == SRC_SPI ? spiByte : otpData;
  wire take = inV && loading;
  wire lastByte = byteIdx_r == 2'h3;
  wire [31:0] wordNxt = {inB, word_r[31:8]};
  wire crcEn = take && (state_r == S_SIZE || state_r == S_PROG);
  wire crcClr = state_r == S_PICK;
  wire crcOk = ~crc == wordNxt;
  wire sizeBig = |wordNxt[31:RAM_AW-2];
  wire [RAM_AW:0] sizeBytes = {1'b0, wordNxt[RAM_AW-3:0], 2'b00};
  wire endTok = tokIn.valid && tokIn.ctrl && tokIn.data == PLB_CTRL_END;
  wire ackNull = ackChan_r == PLB_NULL_CHAN;
  wire otpIssue = otpLoad && !otpPend_r && !otpRd_r;
  plb_pll_t pllNxt;
  assign pllNxt = (state_r == S_LOCK) ? plbPllDecode(pllModeStrap) :
    (state_r == S_RUN && swPllWe) ? swPllCfg : pllCfg_r;

  plb_crc32 u_crc (
    .core_clk(core_clk),
    .resetn(resetn),
    .clr(crcClr),
    .en(crcEn),
    .din(inB),
    .crc_r(crc)
  );

  plb_spi_rx u_spi (
    .core_clk(core_clk),
    .resetn(resetn),
    .run(spiRun),
    .miso(spiMiso),
    .byteV_r(spiByteV),
    .byte_r(spiByte),
    .sck_r(spiSck_r),
    .selN_r(spiSelN_r),
    .mosi_r(spiMosi_r),
    .pinEn_r(spiPinEn_r)
  );

  // PLL settings and ratio
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pllCfg_r <= PLB_PLL_M00;
      ratioNum_r <= 8'h0;
      ratioDen_r <= 10'h0;
    end else begin
      pllCfg_r <= pllNxt;
      ratioNum_r <= {1'b0, pllNxt.feedback} + 8'h1;
      ratioDen_r <= plbPllDen(pllNxt);
    end
  end

  // OTP fetch, private to this tile
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      otpRd_r <= 1'b0;
      otpPend_r <= 1'b0;
      otpAddr_r <= '0;
    end else begin
      otpRd_r <= otpIssue;
      if (otpRd_r) otpPend_r <= 1'b1;
      else if (otpValid) otpPend_r <= 1'b0;
      if (state_r == S_PICK) otpAddr_r <= OTP_AW'(PLB_OTP_BASE);
      else if (otpValid && otpPend_r) otpAddr_r <= otpAddr_r + 1'b1;
    end
  end

  // Link pins: outputs idle low, incoming lines watched
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      linkTraffic_r <= 1'b0;
      bootLinkOutLine0_r <= 1'b0;
      bootLinkOutLine1_r <= 1'b0;
      bootLinkOutOe_r <= 1'b0;
      linkPullDownEn_r <= 1'b1;
    end else begin
      bootLinkOutLine0_r <= 1'b0;
      bootLinkOutLine1_r <= 1'b0;
      bootLinkOutOe_r <= linkBEn_r;
      linkPullDownEn_r <= !linkBEn_r;
      linkTraffic_r <= linkBEn_r && (bootLinkInLine0 || bootLinkInLine1);
    end
  end

  // Boot sequence
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= S_LOCK;
      src_r <= SRC_NONE;
      dlyCnt_r <= 8'h0;
      byteIdx_r <= 2'h0;
      word_r <= 32'h0;
      ackChan_r <= PLB_NULL_CHAN;
      sizeWord_r <= 32'h0;
      ptr_r <= '0;
      left_r <= '0;
      linkBEn_r <= 1'b0;
      intLinksEn_r <= 1'b0;
      chanEnd0Alloc_r <= 1'b0;
      tokOut_r <= '0;
      tokOutDest_r <= 32'h0;
      ramWe_r <= 1'b0;
      ramAddr_r <= '0;
      ramData_r <= 8'h0;
      runStart_r <= 1'b0;
      runPc_r <= '0;
      waitJtag_r <= 1'b0;
      bootReserved_r <= 1'b0;
      bootFail_r <= 1'b0;
    end else begin
      ramWe_r <= 1'b0;
      runStart_r <= 1'b0;
      tokOut_r <= '0;
      if (take) begin
        word_r <= wordNxt;
        byteIdx_r <= byteIdx_r + 2'h1;
      end
      unique case (state_r)
        S_LOCK: if (pllLock) state_r <= S_PICK;
        S_PICK: begin
          src_r <= srcPick;
          byteIdx_r <= 2'h0;
          ptr_r <= RAM_AW'(PLB_RAM_BASE);
          unique case (srcPick)
            SRC_NONE: begin
              waitJtag_r <= 1'b1;
              bootReserved_r <= code01;
              state_r <= S_JTAG;
            end
            SRC_LINK: begin
              dlyCnt_r <= 8'h0;
              state_r <= S_DLY;
            end
            SRC_CHAN: begin
              chanEnd0Alloc_r <= 1'b1;
              state_r <= S_ACK;
            end
            SRC_SPI, SRC_OTP: state_r <= S_SIZE;
          endcase
        end
        S_JTAG: state_r <= S_JTAG;
        S_DLY: begin
          dlyCnt_r <= dlyCnt_r + 8'h1;
          if (dlyCnt_r == 8'(PLB_LINK_DLY_CYC - 1)) begin
            linkBEn_r <= 1'b1;
            intLinksEn_r <= indep;
            chanEnd0Alloc_r <= 1'b1;
            state_r <= S_ACK;
          end
        end
        S_ACK: if (take && lastByte) begin
          ackChan_r <= wordNxt;
          state_r <= S_SIZE;
        end
        S_SIZE: if (take && lastByte) begin
          sizeWord_r <= wordNxt;
          left_r <= sizeBytes;
          if (sizeBig) begin
            bootFail_r <= 1'b1;
            state_r <= S_FAIL;
          end else begin
            state_r <= (wordNxt == 32'h0) ? S_CRC : S_PROG;
          end
        end
        S_PROG: if (take) begin
          ramWe_r <= 1'b1;
          ramAddr_r <= ptr_r;
          ramData_r <= inB;
          ptr_r <= ptr_r + 1'b1;
          left_r <= left_r - 1'b1;
          if (left_r == (RAM_AW + 1)'(1)) state_r <= S_CRC;
        end
        S_CRC: if (take && lastByte) begin
          if (!crcOk) begin
            bootFail_r <= 1'b1;
            state_r <= S_FAIL;
          end else if (fromTok) begin
            state_r <= S_ENDIN;
          end else begin
            runPc_r <= RAM_AW'(PLB_RAM_BASE);
            runStart_r <= 1'b1;
            state_r <= S_RUN;
          end
        end
        S_ENDIN: if (endTok) state_r <= S_ENDOUT;
        S_ENDOUT: begin
          tokOut_r <= '{!ackNull, 1'b1, PLB_CTRL_END};
          tokOutDest_r <= ackChan_r;
          chanEnd0Alloc_r <= 1'b0;
          runPc_r <= RAM_AW'(PLB_RAM_BASE);
          runStart_r <= 1'b1;
          state_r <= S_RUN;
        end
        S_RUN: state_r <= S_RUN;
        S_FAIL: state_r <= S_FAIL;
        default: state_r <= S_FAIL;
      endcase
    end
  end

  modeMap_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    state_r == S_LOCK |=> pllCfg_r == plbPllDecode($past(pllModeStrap)))
    else $error("PLL settings do not follow mode straps");
  swPll_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    state_r == S_RUN && swPllWe |=> pllCfg_r == $past(swPllCfg)
    ##1 ratioDen_r == plbPllDen($past(swPllCfg, 2)))
    else $error("software PLL write lost");
  jtagWait_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    state_r == S_PICK && !secureBoot && code00 |=> waitJtag_r
    && state_r == S_JTAG && !spiPinEn_r && !linkBEn_r)
    else $error("JTAG wait not entered");
  linkDly_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(state_r == S_DLY) |-> !linkBEn_r ##LinkDlyA linkBEn_r)
    else $error("link enable delay wrong");
  linkIdle_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(linkBEn_r) |=> bootLinkOutOe_r && !bootLinkOutLine0_r
    && !bootLinkOutLine1_r && !linkPullDownEn_r)
    else $error("link pins not idle low");
  sizeLsb_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    state_r == S_SIZE && take && lastByte
    |=> sizeWord_r[31:24] == $past(inB))
    else $error("size word byte order wrong");
  ramBase_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(state_r == S_PROG) ##0 take |=> ramWe_r && ramAddr_r == '0)
    else $error("program not loaded at RAM bottom");
  runGood_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    runStart_r |-> runPc_r == '0 && !bootFail_r && $past(ramWe_r, 1) == 1'b0)
    else $error("start without clean CRC");
  endSeq_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    tokOut_r.valid |-> tokOut_r.ctrl && tokOut_r.data == PLB_CTRL_END
    && $past(state_r) == S_ENDOUT && !chanEnd0Alloc_r && runStart_r)
    else $error("END token out of sequence");
  otpStart_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $rose(otpLoad) |-> ##1 otpRd_r && otpAddr_r == '0)
    else $error("OTP read not from address zero");
endmodule : plb_boot_loader

// [rtl/plb_crc32.sv]
// Purpose: Byte-wise reflected CRC-32 accumulator
// Assumes: One byte per enable
// Notes: Final residue is inverted by the caller
module plb_crc32
  import plb_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clr,
  input wire logic en,
  input wire logic [7:0] din,
  output logic [31:0] crc_r
);
  function automatic logic [31:0] crcByte(input logic [31:0] c,
                                          input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ PLB_CRC_POLY) : (x >> 1);
    end
    crcByte = x;
  endfunction : crcByte

  wire [31:0] crcNxt = crcByte(crc_r, din);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_r <= PLB_CRC_INIT;
    end else if (clr) begin
      crc_r <= PLB_CRC_INIT;
    end else if (en) begin
      crc_r <= crcNxt;
    end
  end
endmodule : plb_crc32

// [rtl/plb_spi_rx.sv]
// Purpose: SPI mode 0 master that reads a byte stream from flash
// Assumes: run stays high for the whole read
// Notes: Command and address go out MSB first, data comes in LSB first
module plb_spi_rx
  import plb_pkg::*;
#(
  parameter int HALF = PLB_SPI_HALF_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic miso,
  output logic byteV_r,
  output logic [7:0] byte_r,
  output logic sck_r,
  output logic selN_r,
  output logic mosi_r,
  output logic pinEn_r
);
  initial begin
    if (HALF < 1 || HALF > 255) $error("HALF out of range");
  end

  logic act_r;
  logic tx_r;
  logic [7:0] div_r;
  logic [4:0] bit_r;
  logic [2:0] rxCnt_r;
  logic [31:0] txSh_r;
  logic [7:0] rx_r;
  wire tick = act_r && (div_r == 8'(HALF - 1));
  wire rise = tick && !sck_r;
  wire fall = tick && sck_r;
  wire [7:0] rxNxt = {miso, rx_r[7:1]};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      act_r <= 1'b0;
      tx_r <= 1'b0;
      div_r <= 8'h0;
      bit_r <= 5'h0;
      rxCnt_r <= 3'h0;
      txSh_r <= 32'h0;
      rx_r <= 8'h0;
      byte_r <= 8'h0;
      byteV_r <= 1'b0;
      sck_r <= 1'b0;
      selN_r <= 1'b1;
      mosi_r <= 1'b0;
      pinEn_r <= 1'b0;
    end else begin
      byteV_r <= 1'b0;
      pinEn_r <= run;
      if (!run) begin
        act_r <= 1'b0;
        selN_r <= 1'b1;
        sck_r <= 1'b0;
      end else if (!act_r) begin
        act_r <= 1'b1;
        tx_r <= 1'b1;
        selN_r <= 1'b0;
        div_r <= 8'h0;
        bit_r <= 5'h0;
        rxCnt_r <= 3'h0;
        txSh_r <= {PLB_SPI_READ_CMD, PLB_SPI_START_ADDR};
        mosi_r <= PLB_SPI_READ_CMD[7];
      end else begin
        div_r <= tick ? 8'h0 : div_r + 8'h1;
        if (tick) sck_r <= !sck_r;
        if (fall && tx_r) begin
          txSh_r <= {txSh_r[30:0], 1'b0};
          mosi_r <= txSh_r[30];
          bit_r <= bit_r + 5'h1;
          if (bit_r == 5'h1f) tx_r <= 1'b0;
        end
        if (rise && !tx_r) begin
          rx_r <= rxNxt;
          rxCnt_r <= rxCnt_r + 3'h1;
          if (rxCnt_r == 3'h7) begin
            byte_r <= rxNxt;
            byteV_r <= 1'b1;
          end
        end
      end
    end
  end

  spiIdle_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    selN_r |-> !sck_r) else $error("clock not idle low");
  spiRate_a: assert property (@(posedge core_clk)
    disable iff (!resetn)
    $changed(sck_r) && !selN_r |-> $past(div_r) == 8'(HALF - 1))
    else $error("serial clock edge off rate");
endmodule : plb_spi_rx

// [tb/plb_flash_model.sv]
// Purpose: Behavioural SPI flash holding the boot image
// Assumes: Clock mode 0, image bytes leave low bit first
// Notes: Received command bits are kept in cmd for the bench
module plb_flash_model (
  input wire logic sck,
  input wire logic selN,
  input wire logic mosi,
  output logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] img [0:63];
  logic [31:0] cmd;
  int cnt;
  initial begin
    miso = 1'b0;
    cnt = 0;
    cmd = 32'h0;
  end
  always @(negedge selN) begin
    cnt = 0;
  end
  // Command and address sampled on rising edges
  always @(posedge sck) begin
    if (!selN && cnt < 32) begin
      cmd = {cmd[30:0], mosi};
    end
    cnt = cnt + 1;
  end
  // Image from address zero, launched on falling edges, low bit first
  always @(negedge sck) begin
    if (!selN && cnt >= 32) begin
      miso = img[(cnt - 32) / 8][(cnt - 32) % 8];
    end
  end
  // Released line shows the inverse of its last value
  always @(posedge selN) begin
    miso = ~miso;
  end
endmodule : plb_flash_model

// [tb/tb.sv]
// Purpose: Self-checking bench of the PLL mode and boot loader
// Assumes: Bench drives link tokens and OTP in place of the link layer
// Notes: Inputs change on falling edges
module tb
  import plb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, pllLock, tileId, secureBoot, swPllWe, spiMiso;
  logic [1:0] pllModeStrap;
  logic [4:2] bootStrap;
  plb_pll_t swPllCfg, pllCfg_r;
  logic [7:0] ratioNum_r, otpData, ramData_r;
  logic [9:0] ratioDen_r;
  logic spiSck_r, spiSelN_r, spiMosi_r, spiPinEn_r, linkBEn_r;
  logic intLinksEn_r, linkPullDownEn_r, outL0, outL1, outOe, otpValid;
  logic chanEnd0Alloc_r, otpRd_r, ramWe_r, runStart_r, waitJtag_r;
  logic bootReserved_r, bootFail_r, runSeen, linkTraffic;
  logic [1:0] linkIn;
  plb_tok_t tokIn, tokOut_r, tokSeen;
  logic [31:0] tokOutDest_r, destSeen;
  logic [12:0] otpAddr_r;
  logic [15:0] ramAddr_r, runPc_r, pcSeen;
  logic [7:0] img [$];
  logic [7:0] prog [$];
  int failures, checks, seed, n, m, wrCnt;

  plb_boot_loader i_dut (.core_clk(core_clk), .resetn(resetn),
    .pllLock(pllLock), .pllModeStrap(pllModeStrap), .bootStrap(bootStrap),
    .tileId(tileId), .secureBoot(secureBoot), .swPllWe(swPllWe),
    .swPllCfg(swPllCfg), .pllCfg_r(pllCfg_r), .ratioNum_r(ratioNum_r),
    .ratioDen_r(ratioDen_r), .spiMiso(spiMiso), .spiSck_r(spiSck_r),
    .spiSelN_r(spiSelN_r), .spiMosi_r(spiMosi_r), .spiPinEn_r(spiPinEn_r),
    .linkBEn_r(linkBEn_r), .intLinksEn_r(intLinksEn_r),
    .linkPullDownEn_r(linkPullDownEn_r), .bootLinkOutLine0_r(outL0),
    .bootLinkOutLine1_r(outL1), .bootLinkOutOe_r(outOe),
    .bootLinkInLine0(linkIn[0]), .bootLinkInLine1(linkIn[1]),
    .linkTraffic_r(linkTraffic), .tokIn(tokIn), .tokOut_r(tokOut_r),
    .tokOutDest_r(tokOutDest_r), .chanEnd0Alloc_r(chanEnd0Alloc_r),
    .otpRd_r(otpRd_r), .otpAddr_r(otpAddr_r), .otpData(otpData),
    .otpValid(otpValid), .ramWe_r(ramWe_r), .ramAddr_r(ramAddr_r),
    .ramData_r(ramData_r), .runStart_r(runStart_r), .runPc_r(runPc_r),
    .waitJtag_r(waitJtag_r), .bootReserved_r(bootReserved_r),
    .bootFail_r(bootFail_r));
  plb_flash_model i_flash (.sck(spiSck_r), .selN(spiSelN_r),
    .mosi(spiMosi_r), .miso(spiMiso));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Model of RAM writes and the run pulse
  always @(negedge core_clk) begin
    if (ramWe_r === 1'b1) begin
      check("ram address", ramAddr_r, wrCnt);
      check("ram data", ramData_r, prog[wrCnt]);
      wrCnt++;
    end
    if (runStart_r === 1'b1) begin
      runSeen = 1'b1;
      pcSeen = runPc_r;
      tokSeen = tokOut_r;
      destSeen = tokOutDest_r;
    end
  end

  function automatic logic [31:0] crcByte(input logic [31:0] c,
    input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return c;
  endfunction : crcByte

  task automatic makeImage(input bit bad);
    logic [31:0] c;
    img.delete();
    prog.delete();
    c = 32'hffffffff;
    img = '{8'h02, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) prog.push_back(8'($random(seed)));
    img = {img, prog};
    foreach (img[i]) c = crcByte(c, img[i]);
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) img.push_back(c[8*i +: 8]);
    foreach (img[i]) i_flash.img[i] = img[i];
    wrCnt = 0;
    runSeen = 1'b0;
  endtask : makeImage

  task automatic startBoot(input logic [4:2] s, input logic t, input logic e);
    resetn = 1'b0;
    pllLock = 1'b0;
    bootStrap = s;
    tileId = t;
    secureBoot = e;
    pllModeStrap = 2'($random(seed));
    repeat (3) @(negedge core_clk);
    check("reset pll", pllCfg_r, PLB_PLL_M00);
    resetn = 1'b1;
    @(negedge core_clk);
    pllLock = 1'b1;
  endtask : startBoot

  task automatic waitEnd(input bit bad);
    for (n = 0; n < 40000 && !runSeen && bootFail_r !== 1'b1; n++)
      @(negedge core_clk);
    if (n == 40000) begin
      check("boot finished", 0, 1);
      stop_test();
    end
    @(negedge core_clk);
    check("run start", runSeen, !bad);
    check("fail flag", bootFail_r, bad);
    if (!bad) check("run address", pcSeen, 0);
  endtask : waitEnd

  task automatic linkBoot(input logic [4:2] s, input logic t,
    input logic [31:0] ack, input bit bad);
    logic lk;
    lk = s[4] | ~t;
    makeImage(bad);
    startBoot(s, t, 1'b0);
    for (n = 0; n < 40 && chanEnd0Alloc_r !== 1'b1; n++) @(negedge core_clk);
    check("chan alloc", chanEnd0Alloc_r, 1);
    check("link enable", {linkBEn_r, intLinksEn_r}, {lk, s[4]});
    if (lk) check("enable delay", n >= 18 && n <= 26, 1);
    @(negedge core_clk);
    check("link pins", {linkPullDownEn_r, outOe, outL0, outL1},
      {~lk, lk, 2'b00});
    linkIn = 2'($random(seed)) | 2'b01;
    @(negedge core_clk);
    check("link traffic", linkTraffic, lk);
    linkIn = 2'b00;
    for (int i = 0; i < 4; i++) begin
      tokIn = '{1'b1, 1'b0, ack[8*i +: 8]};
      @(negedge core_clk);
    end
    foreach (img[i]) begin
      tokIn = '{1'b1, 1'b0, img[i]};
      @(negedge core_clk);
    end
    tokIn = '{1'b1, 1'b1, PLB_CTRL_END};
    @(negedge core_clk);
    tokIn = '0;
    waitEnd(bad);
    if (!bad) begin
      check("ack valid", tokSeen.valid, ack != PLB_NULL_CHAN);
      if (ack != PLB_NULL_CHAN)
        check("ack token", tokSeen, {1'b1, 1'b1, PLB_CTRL_END});
      if (ack != PLB_NULL_CHAN)
        check("ack dest", destSeen, ack);
      check("chan freed", chanEnd0Alloc_r, 0);
      check("bytes loaded", wrCnt, 8);
    end
  endtask : linkBoot

  task automatic spiBoot(input logic [4:2] s, input logic t);
    makeImage(1'b0);
    startBoot(s, t, 1'b0);
    for (n = 0; n < 100 && spiSelN_r !== 1'b0; n++) @(negedge core_clk);
    check("spi select", spiSelN_r, 0);
    check("spi pins", spiPinEn_r, 1);
    for (n = 0; n < 400 && spiSck_r !== 1'b1; n++) @(negedge core_clk);
    for (n = 0; n < 400 && spiSck_r !== 1'b0; n++) @(negedge core_clk);
    for (m = 0; m < 400 && spiSck_r !== 1'b1; m++) @(negedge core_clk);
    // 400 MHz over 2.5 MHz gives a 160 cycle period
    check("sck period", n + m, 160);
    waitEnd(1'b0);
    check("read command", i_flash.cmd, {PLB_SPI_READ_CMD, 24'h0});
    check("bytes loaded", wrCnt, 8);
  endtask : spiBoot

  initial begin
    seed = 32'hbe69;
    failures = 0;
    checks = 0;
    {swPllWe, otpValid, otpData, tokIn, swPllCfg, linkIn} = '0;
    {pllModeStrap, bootStrap, tileId, secureBoot, pllLock, resetn} = '0;
    repeat (3) @(negedge core_clk);
    check("reset pll", pllCfg_r, PLB_PLL_M00);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      pllModeStrap = 2'(i);
      repeat (2) @(negedge core_clk);
      m = (i == 0) ? 122 : (i == 1) ? 23 : (i == 2) ? 49 : 119;
      n = (i == 0) ? 1 : 2;
      check("pll mode", pllCfg_r, {n[1:0], m[6:0], 6'h00});
      check("ratio num", ratioNum_r, m + 1);
      check("ratio den", ratioDen_r, 2 * (n + 1));
    end
    for (int i = 0; i < 2; i++) begin
      startBoot({1'(i), 1'b0, 1'(i)}, 1'b0, 1'b0);
      repeat (40) @(negedge core_clk);
      check("wait state", {waitJtag_r | bootReserved_r, bootReserved_r,
        linkBEn_r, spiSelN_r}, {1'b1, 1'(i), 2'b01});
    end
    linkBoot(3'b010, 1'b0, $random(seed), 1'b0);
    swPllCfg = '{2'h3, 7'($random(seed)), 6'h02};
    swPllWe = 1'b1;
    @(negedge core_clk);
    swPllWe = 1'b0;
    @(negedge core_clk);
    check("sw pll", pllCfg_r, swPllCfg);
    check("sw den", ratioDen_r, 24);
    linkBoot(3'b110, 1'b1, PLB_NULL_CHAN, 1'b0);
    linkBoot(3'b010, 1'b1, $random(seed), 1'b1);
    spiBoot(3'b011, 1'b0);
    spiBoot(3'b111, 1'b1);
    makeImage(1'b0);
    startBoot(3'b111, 1'b0, 1'b1);
    foreach (img[i]) begin
      for (n = 0; n < 50 && otpRd_r !== 1'b1; n++) @(negedge core_clk);
      check("otp read", otpRd_r, 1);
      check("otp address", otpAddr_r, i);
      @(negedge core_clk);
      otpData = img[i];
      otpValid = 1'b1;
      @(negedge core_clk);
      otpValid = 1'b0;
    end
    waitEnd(1'b0);
    stop_test();
  end
endmodule : tb
